/* File: design/dcua_pkg.sv */
// dcua_pkg: constants shared by the double-check filter and unset-id alarm block.
// assumes a 32-bit avalon-mm register bus with word-aligned byte addresses.
package dcua_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] DCUA_OFS_CTRL      = 8'h00;
	localparam logic [7:0] DCUA_OFS_WCHK      = 8'h04;
	localparam logic [7:0] DCUA_OFS_STATUS    = 8'h08;
	localparam logic [7:0] DCUA_OFS_ERR_CODE  = 8'h0c;
	localparam logic [7:0] DCUA_OFS_ERR_ID    = 8'h10;
	localparam logic [7:0] DCUA_OFS_ALARM_ID  = 8'h14;
	localparam logic [7:0] DCUA_OFS_IRQ_STAT  = 8'h18;
	localparam logic [7:0] DCUA_OFS_IRQ_MASK  = 8'h1c;
	localparam logic [7:0] DCUA_OFS_DATA_BASE = 8'h40;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int DCUA_CTRL_ERR_RST_BIT   = 0;
	localparam int DCUA_STAT_ALARM_BIT     = 0;
	localparam int DCUA_STAT_DET_BIT       = 1;
	localparam int DCUA_STAT_CNT_LSB       = 8;
	localparam int DCUA_IRQ_UNSET_BIT      = 0;
	localparam int DCUA_IRQ_DISCARD_BIT    = 1;
	localparam int DCUA_IRQ_BITS           = 2;

	// ------------------------------------------------------------
	// values
	// ------------------------------------------------------------
	localparam logic [15:0] DCUA_ID_DEF_INPUT   = 16'h02ff;
	localparam logic [15:0] DCUA_ID_DEF_OUTPUT  = 16'h00ff;
	localparam logic [15:0] DCUA_ERR_UNSET_ID   = 16'h0191;
	localparam logic [15:0] DCUA_RST_ERR        = 16'h0000;
	localparam logic [4:0]  DCUA_RST_WCHK       = 5'h00;
	localparam logic [1:0]  DCUA_RST_IRQ        = 2'h0;
	localparam int          DCUA_WORD_BITS      = 16;

	function automatic logic is_unset_id(input logic [15:0] id);
		return (id == DCUA_ID_DEF_INPUT) || (id == DCUA_ID_DEF_OUTPUT);
	endfunction

endpackage

/* File: design/dcua_uid_if.sv */
// dcua_uid_if: carries detected ids into the unset-id detector and its findings back.
// assumes both ends run on the block clock.
interface dcua_uid_if;
	logic        det_start;
	logic        id_valid;
	logic [15:0] id;
	logic        hit;
	logic [15:0] hit_id;
	logic [1:0]  id_count;
	logic [15:0] alarm_id;

	modport ctl (output det_start, output id_valid, output id,
	             input hit, input hit_id, input id_count, input alarm_id);
	modport det (input det_start, input id_valid, input id,
	             output hit, output hit_id, output id_count, output alarm_id);
endinterface

/* File: design/dcua_uid_det.sv */
// dcua_uid_det: spots factory-default slave ids during automatic address detection.
// assumes id_valid pulses once per slave reported by the address scan.
module dcua_uid_det
	import dcua_pkg::*;
(
	input  wire logic mclk_i,
	input  wire logic sys_rst_i,
	dcua_uid_if.det   u
);

	logic        seen_in;
	logic        seen_out;
	logic [1:0]  id_count;
	logic [15:0] alarm_id;
	logic        hit;
	logic [15:0] hit_id;
	logic        next_seen_in;
	logic        next_seen_out;
	logic [1:0]  next_id_count;
	logic [15:0] next_alarm_id;
	logic        next_hit;
	logic [15:0] next_hit_id;

	always_comb begin
		logic first;
		first         = 1'b0;
		next_seen_in  = seen_in;
		next_seen_out = seen_out;
		next_id_count = id_count;
		next_alarm_id = alarm_id;
		next_hit      = 1'b0;
		next_hit_id   = hit_id;
		// a new scan forgets the previous result
		if (u.det_start) begin
			next_seen_in  = 1'b0;
			next_seen_out = 1'b0;
			next_id_count = 2'd0;
			next_alarm_id = DCUA_RST_ERR;
		end else if (u.id_valid && is_unset_id(u.id)) begin
			// many slaves sharing one default id count once
			if (u.id == DCUA_ID_DEF_INPUT) begin
				first        = !seen_in;
				next_seen_in = 1'b1;
			end else begin
				first         = !seen_out;
				next_seen_out = 1'b1;
			end
			if (first) begin
				next_id_count = 2'(id_count + 2'd1);
				next_alarm_id = u.id;
				next_hit      = 1'b1;
				next_hit_id   = u.id;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			seen_in  <= 1'b0;
			seen_out <= 1'b0;
			id_count <= 2'd0;
			alarm_id <= DCUA_RST_ERR;
			hit      <= 1'b0;
			hit_id   <= DCUA_RST_ERR;
		end else begin
			seen_in  <= next_seen_in;
			seen_out <= next_seen_out;
			id_count <= next_id_count;
			alarm_id <= next_alarm_id;
			hit      <= next_hit;
			hit_id   <= next_hit_id;
		end
	end

	assign u.hit      = hit;
	assign u.hit_id   = hit_id;
	assign u.id_count = id_count;
	assign u.alarm_id = alarm_id;

endmodule

/* File: design/dcua_dchk.sv */
// dcua_dchk: double-check filter over one transmission cycle of received points.
// assumes cyc_valid_i pulses once per completed transmission cycle.
module dcua_dchk
	import dcua_pkg::*;
#(
	parameter int NPTS = 256
)(
	input  wire logic            mclk_i,
	input  wire logic            sys_rst_i,
	input  wire logic            cyc_valid_i,
	input  wire logic [NPTS-1:0] cyc_data_i,
	input  wire logic [4:0]      wchk_words_i,
	output logic      [NPTS-1:0] acc_data_o,
	output logic                 discard_o
);

	localparam int NWORDS = NPTS / DCUA_WORD_BITS;

	logic [NPTS-1:0] ref_data;
	logic            ref_ok;
	logic            discard;
	logic [NPTS-1:0] next_ref_data;
	logic            next_ref_ok;
	logic [NPTS-1:0] next_acc;
	logic            next_discard;

	always_comb begin
		logic [DCUA_WORD_BITS-1:0] eq;
		logic                      in_word;
		eq            = '0;
		in_word       = 1'b0;
		next_ref_data = ref_data;
		next_ref_ok   = ref_ok;
		next_acc      = acc_data_o;
		next_discard  = 1'b0;
		if (cyc_valid_i) begin
			next_ref_data = cyc_data_i;
			next_ref_ok   = 1'b1;
			for (int w = 0; w < NWORDS; w++) begin
				eq      = ~(cyc_data_i[w*DCUA_WORD_BITS +: DCUA_WORD_BITS]
				          ^ ref_data[w*DCUA_WORD_BITS +: DCUA_WORD_BITS]);
				// words 0..N-1 are checked whole, whatever slave sits there
				in_word = (w < int'(wchk_words_i));
				if (!ref_ok) begin
					next_discard = 1'b1;
				end else if (in_word) begin
					if (&eq)
						next_acc[w*DCUA_WORD_BITS +: DCUA_WORD_BITS] =
							cyc_data_i[w*DCUA_WORD_BITS +: DCUA_WORD_BITS];
					else
						next_discard = 1'b1;
				end else begin
					for (int b = 0; b < DCUA_WORD_BITS; b++) begin
						if (eq[b])
							next_acc[w*DCUA_WORD_BITS+b] = cyc_data_i[w*DCUA_WORD_BITS+b];
						else
							next_discard = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			ref_data   <= '0;
			ref_ok     <= 1'b0;
			acc_data_o <= '0;
			discard    <= 1'b0;
		end else begin
			ref_data   <= next_ref_data;
			ref_ok     <= next_ref_ok;
			acc_data_o <= next_acc;
			discard    <= next_discard;
		end
	end

	assign discard_o = discard;

endmodule

/* File: design/dcua_top.sv */
// dcua_top: double-check input filter and unset-id alarm of a sensor-network master,
// with an avalon-mm register slave and one level interrupt.
// assumes the link receiver runs on mclk_i and hands over whole transmission cycles.
//
// Summary of operation
// - during address scan, flag slaves at default id 02ffh or 00ffh
// - an unset-id slave raises the slave alarm flag
// - an unset-id slave loads error code 0191h into the latest error code
// - an unset-id slave loads its id into the latest error id
// - latest error registers keep only the most recent error
// - cyclic transmission keeps running while the alarm is raised
// - slaves sharing one unset id give one entry: count 1, that id
// - result is lost at power-up and reported again after a new scan
// - error reset request turned on then off, or power cycle, clears error
// - error reset clears alarm flag, latest error code and latest error id
// - received data accepted only when equal to the previous cycle
// - 1-bit mode: each bit updates only when it matches its previous value
// - word mode: a 16-bit word updates only when all its bits match
// - word check applies to every address in range, bit slaves included
// - setting of n words covers addresses 0 to 16n-1, bits beyond
module dcua_top
	import dcua_pkg::*;
#(
	parameter int NPTS = 256
)(
	input  wire logic            mclk_i,
	input  wire logic            sys_rst_i,
	// avalon-mm slave
	input  wire logic [7:0]      avs_address_i,
	input  wire logic            avs_read_i,
	input  wire logic            avs_write_i,
	input  wire logic [31:0]     avs_writedata_i,
	output logic      [31:0]     avs_readdata_o,
	output logic                 avs_waitrequest_o,
	// link receiver, same clock
	input  wire logic            cyc_valid_i,
	input  wire logic [NPTS-1:0] cyc_data_i,
	input  wire logic            scan_active_i,
	input  wire logic            scan_id_valid_i,
	input  wire logic [15:0]     scan_id_i,
	// controller side
	output logic      [NPTS-1:0] io_data_o,
	output logic                 slave_alarm_o,
	output logic                 irq_o
);

	localparam int NWORDS = NPTS / DCUA_WORD_BITS;

	// ------------------------------------------------------------
	// sub-blocks
	// ------------------------------------------------------------
	dcua_uid_if uif ();

	logic [4:0] wchk_words;
	logic       discard;
	logic       scan_q;

	dcua_dchk #(
		.NPTS (NPTS)
	) u_dchk (
		.mclk_i       (mclk_i),
		.sys_rst_i    (sys_rst_i),
		.cyc_valid_i  (cyc_valid_i),
		.cyc_data_i   (cyc_data_i),
		.wchk_words_i (wchk_words),
		.acc_data_o   (io_data_o),
		.discard_o    (discard)
	);

	dcua_uid_det u_det (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.u         (uif.det)
	);

	// a scan starts on the rising edge of scan_active_i
	assign uif.det_start = scan_active_i && !scan_q;
	assign uif.id_valid  = scan_active_i && scan_id_valid_i;
	assign uif.id        = scan_id_i;

	// ------------------------------------------------------------
	// bus handshake
	// ------------------------------------------------------------
	// every access waits exactly one cycle so read data can come from a flop
	logic        ack;
	logic        next_ack;
	logic [31:0] next_rdata;
	logic        req;
	logic        wr_go;
	logic        rd_go;

	assign req               = avs_read_i || avs_write_i;
	assign avs_waitrequest_o = req && !ack;
	assign rd_go             = avs_read_i && !ack;
	assign wr_go             = avs_write_i && ack;
	assign next_ack          = req && !ack;

	// ------------------------------------------------------------
	// control and error state
	// ------------------------------------------------------------
	logic                     err_rst_req;
	logic                     err_rst_q;
	logic                     alarm;
	logic [15:0]              err_code;
	logic [15:0]              err_id;
	logic [DCUA_IRQ_BITS-1:0] irq_stat;
	logic [DCUA_IRQ_BITS-1:0] irq_mask;

	logic                     next_err_rst_req;
	logic                     next_err_rst_q;
	logic [4:0]               next_wchk_words;
	logic                     next_alarm;
	logic [15:0]              next_err_code;
	logic [15:0]              next_err_id;
	logic [DCUA_IRQ_BITS-1:0] next_irq_stat;
	logic [DCUA_IRQ_BITS-1:0] next_irq_mask;
	logic                     next_scan_q;

	always_comb begin
		logic                     err_clear;
		logic [DCUA_IRQ_BITS-1:0] ev;
		// the clear acts when the request flag goes from on to off
		err_clear        = err_rst_q && !err_rst_req;
		ev               = '0;
		next_err_rst_req = err_rst_req;
		next_wchk_words  = wchk_words;
		next_irq_mask    = irq_mask;
		next_scan_q      = scan_active_i;
		next_err_rst_q   = err_rst_req;
		next_alarm       = alarm;
		next_err_code    = err_code;
		next_err_id      = err_id;
		next_irq_stat    = irq_stat;

		if (wr_go) begin
			unique case (avs_address_i)
				DCUA_OFS_CTRL:     next_err_rst_req = avs_writedata_i[DCUA_CTRL_ERR_RST_BIT];
				DCUA_OFS_WCHK:     next_wchk_words  = avs_writedata_i[4:0];
				DCUA_OFS_IRQ_STAT: next_irq_stat    = irq_stat & ~avs_writedata_i[DCUA_IRQ_BITS-1:0];
				DCUA_OFS_IRQ_MASK: next_irq_mask    = avs_writedata_i[DCUA_IRQ_BITS-1:0];
				default:           next_err_rst_req = err_rst_req;
			endcase
		end

		if (err_clear) begin
			next_alarm    = 1'b0;
			next_err_code = DCUA_RST_ERR;
			next_err_id   = DCUA_RST_ERR;
		end
		// a new finding wins over a clear in the same cycle
		if (uif.hit) begin
			next_alarm    = 1'b1;
			next_err_code = DCUA_ERR_UNSET_ID;
			next_err_id   = uif.hit_id;
		end

		ev[DCUA_IRQ_UNSET_BIT]   = uif.hit;
		ev[DCUA_IRQ_DISCARD_BIT] = discard;
		next_irq_stat            = next_irq_stat | ev;
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			ack         <= 1'b0;
			err_rst_req <= 1'b0;
			err_rst_q   <= 1'b0;
			wchk_words  <= DCUA_RST_WCHK;
			alarm       <= 1'b0;
			err_code    <= DCUA_RST_ERR;
			err_id      <= DCUA_RST_ERR;
			irq_stat    <= DCUA_RST_IRQ;
			irq_mask    <= DCUA_RST_IRQ;
			scan_q      <= 1'b0;
		end else begin
			ack         <= next_ack;
			err_rst_req <= next_err_rst_req;
			err_rst_q   <= next_err_rst_q;
			wchk_words  <= next_wchk_words;
			alarm       <= next_alarm;
			err_code    <= next_err_code;
			err_id      <= next_err_id;
			irq_stat    <= next_irq_stat;
			irq_mask    <= next_irq_mask;
			scan_q      <= next_scan_q;
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	always_comb begin
		logic [7:0] widx;
		widx       = 8'((avs_address_i - DCUA_OFS_DATA_BASE) >> 2);
		next_rdata = avs_readdata_o;
		if (rd_go) begin
			next_rdata = '0;
			unique case (avs_address_i)
				DCUA_OFS_CTRL:     next_rdata[DCUA_CTRL_ERR_RST_BIT] = err_rst_req;
				DCUA_OFS_WCHK:     next_rdata[4:0]  = wchk_words;
				DCUA_OFS_STATUS: begin
					next_rdata[DCUA_STAT_ALARM_BIT]                 = alarm;
					next_rdata[DCUA_STAT_DET_BIT]                   = scan_q;
					next_rdata[DCUA_STAT_CNT_LSB +: 2]              = uif.id_count;
				end
				DCUA_OFS_ERR_CODE: next_rdata[15:0] = err_code;
				DCUA_OFS_ERR_ID:   next_rdata[15:0] = err_id;
				DCUA_OFS_ALARM_ID: next_rdata[15:0] = uif.alarm_id;
				DCUA_OFS_IRQ_STAT: next_rdata[DCUA_IRQ_BITS-1:0] = irq_stat;
				DCUA_OFS_IRQ_MASK: next_rdata[DCUA_IRQ_BITS-1:0] = irq_mask;
				default: begin
					// data window: one accepted 16-bit word per bus word
					if (avs_address_i >= DCUA_OFS_DATA_BASE && avs_address_i[1:0] == 2'b00
					    && int'(widx) < NWORDS)
						next_rdata[15:0] = io_data_o[int'(widx)*DCUA_WORD_BITS +: DCUA_WORD_BITS];
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i)
			avs_readdata_o <= '0;
		else
			avs_readdata_o <= next_rdata;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// the filter is never gated by the alarm, so transmission carries on
	assign slave_alarm_o = alarm;
	assign irq_o         = |(irq_stat & irq_mask);

endmodule

/* File: sim/dcua_chk.sv */
// dcua_chk: port-level assertions for dcua_top, bound into every instance.
// assumes one clock domain with synchronous active-high reset.
module dcua_chk
	import dcua_pkg::*;
#(
	parameter int NPTS = 256
)(
	input wire logic            mclk_i,
	input wire logic            sys_rst_i,
	input wire logic [7:0]      avs_address_i,
	input wire logic            avs_read_i,
	input wire logic            avs_write_i,
	input wire logic [31:0]     avs_writedata_i,
	input wire logic            avs_waitrequest_o,
	input wire logic            cyc_valid_i,
	input wire logic [NPTS-1:0] cyc_data_i,
	input wire logic            scan_active_i,
	input wire logic            scan_id_valid_i,
	input wire logic [15:0]     scan_id_i,
	input wire logic [NPTS-1:0] io_data_o,
	input wire logic            slave_alarm_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	logic            flag_q;
	logic [NPTS-1:0] ref_q;
	wire             ctrl_wr = avs_write_i && !avs_waitrequest_o && (avs_address_i == DCUA_OFS_CTRL);
	wire             unset_w = scan_active_i && scan_id_valid_i && (scan_id_i == 16'h02ff || scan_id_i == 16'h00ff);
	// stale reference after a reset is harmless: the first cycle changes nothing
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) flag_q <= 1'b0;
		else if (ctrl_wr) flag_q <= avs_writedata_i[0];
		if (cyc_valid_i) ref_q <= cyc_data_i;
	end
	sequence s_unset;
		unset_w;
	endsequence
	sequence s_clear;
		ctrl_wr && !avs_writedata_i[0] && flag_q && !scan_active_i;
	endsequence

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	a_wait_once: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("waitrequest held longer than one cycle");
	a_wait_idle: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
		else $error("waitrequest without request");
	a_io_hold: assert property (!cyc_valid_i |=> $stable(io_data_o))
		else $error("io data changed without a cycle");
	a_io_new: assert property (cyc_valid_i |=> ((io_data_o ^ $past(io_data_o)) &
		(io_data_o ^ $past(cyc_data_i))) == '0) else $error("io bit changed to a value not received");
	a_io_ref: assert property (cyc_valid_i |=> ((io_data_o ^ $past(io_data_o)) &
		($past(cyc_data_i) ^ $past(ref_q))) == '0) else $error("io bit updated without a match");
	a_alarm_set: assert property (s_unset |-> ##[2:3] slave_alarm_o)
		else $error("default id not flagged");
	a_alarm_cause: assert property ($rose(slave_alarm_o) |-> $past(unset_w, 2) || $past(unset_w, 3))
		else $error("alarm raised without a default id");
	a_alarm_clr: assert property (s_clear |-> ##[2:3] !slave_alarm_o)
		else $error("alarm not cleared by error reset");
endmodule

bind dcua_top dcua_chk #(.NPTS(NPTS)) chk (
	.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_waitrequest_o(avs_waitrequest_o),
	.cyc_valid_i(cyc_valid_i), .cyc_data_i(cyc_data_i), .scan_active_i(scan_active_i),
	.scan_id_valid_i(scan_id_valid_i), .scan_id_i(scan_id_i), .io_data_o(io_data_o),
	.slave_alarm_o(slave_alarm_o)
);

/* File: sim/dcua_slv.sv */
// dcua_slv: behavioural model of the slave modules behind the link receiver.
// assumes its tasks are called just after a rising edge of mclk_i.
module dcua_slv (
	input  wire logic   mclk_i,
	output logic        cyc_valid_o,
	output logic [255:0] cyc_data_o,
	output logic        scan_active_o,
	output logic        scan_id_valid_o,
	output logic [15:0] scan_id_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cyc_valid_o = 1'b0;
		cyc_data_o = '0;
		scan_active_o = 1'b0;
		scan_id_valid_o = 1'b0;
		scan_id_o = 16'h0000;
	end
	// word slaves start on 16-point boundaries, so words line up with checked words
	// between cycles the data lines carry the inverse so no stale value passes for data
	task automatic send(input logic [255:0] d);
		cyc_valid_o <= 1'b1;
		cyc_data_o <= d;
		@(posedge mclk_i);
		cyc_valid_o <= 1'b0;
		cyc_data_o <= ~d;
		repeat (3) @(posedge mclk_i);
	endtask
	// every call is a fresh address detection run, as needed after assigning ids
	task automatic scan(input logic [15:0] ids [3]);
		scan_active_o <= 1'b1;
		@(posedge mclk_i);
		foreach (ids[i]) begin
			scan_id_valid_o <= 1'b1;
			scan_id_o <= ids[i];
			@(posedge mclk_i);
			scan_id_valid_o <= 1'b0;
			scan_id_o <= ~ids[i];
			@(posedge mclk_i);
		end
		repeat (4) @(posedge mclk_i);
		scan_active_o <= 1'b0;
		repeat (2) @(posedge mclk_i);
	endtask
endmodule

/* File: sim/dcua_tb.sv */
// dcua_tb: register-level bench for dcua_top with the slave model on the link side.
// assumes the design package and a 25 MHz block clock.
module tb
	import dcua_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [255:0] P0 = {16{16'h5a3c}};
	localparam logic [255:0] M  = (256'h1 << 40) | (256'h1 << 20) | 256'h8;
	logic         mclk_i = 1'b0;
	logic         sys_rst_i = 1'b1;
	logic         rd = 1'b0;
	logic         wr = 1'b0;
	logic [7:0]   addr = 8'h00;
	logic [31:0]  wdata = 32'h0;
	logic [31:0]  rdata;
	logic [31:0]  q;
	logic         wreq;
	logic         cv, sa, siv, alarm, irq, have_ref;
	logic [15:0]  sid;
	logic [255:0] cd, io, exp_io, prev;
	logic [7:0]   ofs [9] = '{DCUA_OFS_CTRL, DCUA_OFS_WCHK, DCUA_OFS_STATUS, DCUA_OFS_ERR_CODE, DCUA_OFS_ERR_ID,
	                          DCUA_OFS_ALARM_ID, DCUA_OFS_IRQ_STAT, DCUA_OFS_IRQ_MASK, 8'h20};
	int           wks [3] = '{0, 2, 16};
	int           wk;
	int           fail_count = 0;
	int           n_tests = 0;

	dcua_top #(.NPTS(256)) uut (
		.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .cyc_valid_i(cv),
		.cyc_data_i(cd), .scan_active_i(sa), .scan_id_valid_i(siv), .scan_id_i(sid), .io_data_o(io),
		.slave_alarm_o(alarm), .irq_o(irq)
	);
	dcua_slv slv (.mclk_i(mclk_i), .cyc_valid_o(cv), .cyc_data_o(cd), .scan_active_o(sa),
		.scan_id_valid_o(siv), .scan_id_o(sid));

	initial begin
		forever #20 mclk_i = ~mclk_i;
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [255:0] seen, input logic [255:0] expv);
		n_tests++;
		if (seen !== expv) begin
			fail_count++;
			$display("[FAIL] %s expected %0h seen %0h", nm, expv, seen);
		end
	endtask
	// waitrequest and read data are taken at the rising edge, before that edge's updates land
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int   n;
		logic ok;
		n = 0;
		ok = 1'b0;
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		while (!ok && n < 16) begin
			@(posedge mclk_i);
			n++;
			ok = (wreq === 1'b0);
		end
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge mclk_i);
		if (!ok) begin
			fail_count++;
			print_verdict();
		end
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(nm, {224'h0, q}, {224'h0, e});
	endtask
	task automatic do_reset();
		sys_rst_i <= 1'b1;
		repeat (10) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		@(posedge mclk_i);
		have_ref = 1'b0;
		exp_io = '0;
		prev = '0;
		wk = 0;
	endtask
	// expected filter: a differing bit keeps its old value, inside checked words the whole word does
	task automatic link(input logic [255:0] cur);
		logic [255:0] m;
		m = cur ^ prev;
		for (int k = 0; k < wk; k++) if (|m[16*k +: 16]) m[16*k +: 16] = 16'hffff;
		if (have_ref) exp_io = (exp_io & m) | (cur & ~m);
		have_ref = 1'b1;
		prev = cur;
		slv.send(cur);
		check("io_data", io, exp_io);
	endtask

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		do_reset();
		foreach (ofs[i]) rchk("reset value", ofs[i], 32'h0);
		bus(1'b1, 8'h20, 32'hffffffff);
		bus(1'b1, DCUA_OFS_ERR_CODE, 32'hffff);
		rchk("unmapped", 8'h20, 32'h0);
		rchk("code read-only", DCUA_OFS_ERR_CODE, 32'h0);
		foreach (wks[j]) begin
			wk = wks[j];
			bus(1'b1, DCUA_OFS_WCHK, 32'(wk));
			rchk("word check", DCUA_OFS_WCHK, 32'(wk));
			link(P0);
			link(P0);
			link(~P0);
			link(~P0 ^ M);
			rchk("data word 2", DCUA_OFS_DATA_BASE + 8'h08, {16'h0, exp_io[47:32]});
		end
		rchk("discard flag", DCUA_OFS_IRQ_STAT, 32'h2);
		bus(1'b1, DCUA_OFS_IRQ_STAT, 32'h2);
		slv.scan('{16'h0005, 16'h02ff, 16'h02ff});
		check("alarm", alarm, 1'b1);
		rchk("error code", DCUA_OFS_ERR_CODE, 32'h0191);
		rchk("error id", DCUA_OFS_ERR_ID, 32'h02ff);
		rchk("alarm id", DCUA_OFS_ALARM_ID, 32'h02ff);
		rchk("status", DCUA_OFS_STATUS, 32'h101);
		link(~P0);
		link(~P0);
		slv.scan('{16'h02ff, 16'h00ff, 16'h0007});
		rchk("error id", DCUA_OFS_ERR_ID, 32'h00ff);
		rchk("status", DCUA_OFS_STATUS, 32'h201);
		bus(1'b1, DCUA_OFS_CTRL, 32'h1);
		rchk("reset request", DCUA_OFS_CTRL, 32'h1);
		repeat (3) @(posedge mclk_i);
		check("alarm", alarm, 1'b1);
		bus(1'b1, DCUA_OFS_CTRL, 32'h0);
		repeat (3) @(posedge mclk_i);
		check("alarm", alarm, 1'b0);
		rchk("error code", DCUA_OFS_ERR_CODE, 32'h0);
		rchk("error id", DCUA_OFS_ERR_ID, 32'h0);
		slv.scan('{16'h0001, 16'h02ff, 16'h0002});
		do_reset();
		check("alarm", alarm, 1'b0);
		rchk("status", DCUA_OFS_STATUS, 32'h0);
		slv.scan('{16'h00ff, 16'h00ff, 16'h0001});
		rchk("status", DCUA_OFS_STATUS, 32'h101);
		rchk("error id", DCUA_OFS_ERR_ID, 32'h00ff);
		check("irq masked", irq, 1'b0);
		bus(1'b1, DCUA_OFS_IRQ_MASK, 32'h1);
		check("irq", irq, 1'b1);
		bus(1'b1, DCUA_OFS_IRQ_STAT, 32'h1);
		check("irq cleared", irq, 1'b0);
		link(P0);
		check("irq masked", irq, 1'b0);
		bus(1'b1, DCUA_OFS_IRQ_MASK, 32'h3);
		check("irq", irq, 1'b1);
		print_verdict();
	end
endmodule
